// file: design/rsl_pkg.sv
package rsl_pkg;
	localparam int         STRAP_W       = 8;
	localparam int         ADDR_W        = 5;
	localparam int         RADDR_W       = 4;
	localparam int         RDATA_W       = 16;
	localparam int         ADV_W         = 4;

	// Pin order on the strap bus
	localparam int         PIN_ADDR_LO   = 0;
	localparam int         PIN_ABIL_LOW  = 5;
	localparam int         PIN_ABIL_HIGH = 6;
	localparam int         PIN_NEG_EN    = 7;

	// Values seen with only the internal pulls, and the address that isolates the MII
	localparam logic [4:0] ADDR_DEFAULT  = 5'h01;
	localparam logic [2:0] NEG_DEFAULT   = 3'h7;
	localparam logic [4:0] ISOLATE_ADDR  = 5'h00;

	// Register offsets on the plain port
	localparam logic [3:0] OFS_CTRL      = 4'h0;
	localparam logic [3:0] OFS_BASIC     = 4'h1;
	localparam logic [3:0] OFS_ADV       = 4'h2;
	localparam logic [3:0] OFS_STRAP     = 4'h3;

	// Field positions
	localparam int         CTRL_ISO_BIT  = 5;
	localparam int         BAS_NEG_BIT   = 0;
	localparam int         BAS_SPD_BIT   = 1;
	localparam int         BAS_DPX_BIT   = 2;
	localparam int         STR_VAL_BIT   = 8;

	// Advertisement bits: {100 full, 100 half, 10 full, 10 half}
	localparam logic [3:0] ADV_10_BOTH   = 4'h3;
	localparam logic [3:0] ADV_100_BOTH  = 4'hc;
	localparam logic [3:0] ADV_HALF_BOTH = 4'h5;
	localparam logic [3:0] ADV_ALL       = 4'hf;

	typedef enum logic [1:0] {
		RSL_ST_CAPTURE = 2'b00,
		RSL_ST_RUN     = 2'b01
	} rsl_state_e;
endpackage

// file: design/rsl_sync.sv
`timescale 1ns/1ns
module rsl_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] hold;
	} rsl_sync_s;

	rsl_sync_s st_ff;
	rsl_sync_s nxt_st;

	// No reset: the pins must be followed while hardware reset is held
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.meta = d;
		nxt_st.hold = st_ff.meta;
	end

	always_ff @(posedge mclk) begin
		st_ff <= nxt_st;
	end

	assign q = st_ff.hold;
endmodule

// file: design/rsl_mode_dec.sv
`timescale 1ns/1ns
module rsl_mode_dec (
	input  wire logic       abil_high,
	input  wire logic       abil_low,
	output logic            speed_100,
	output logic            full_duplex,
	output logic      [3:0] adv
);
	always_comb begin
		speed_100   = abil_high;
		full_duplex = abil_low;
		case ({abil_high, abil_low})
			2'h0: begin
				adv = rsl_pkg::ADV_10_BOTH;
			end
			2'h1: begin
				adv = rsl_pkg::ADV_100_BOTH;
			end
			2'h2: begin
				adv = rsl_pkg::ADV_HALF_BOTH;
			end
			default: begin
				adv = rsl_pkg::ADV_ALL;
			end
		endcase
	end
endmodule

// file: design/rsl_strap_latch.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module rsl_strap_latch (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic  [7:0] strap_pin_in,
	output logic       [7:0] strap_pin_out,
	output logic       [7:0] strap_pin_oe,
	input  wire logic  [4:0] mii_func_out,
	input  wire logic  [2:0] indicator_func_out,
	input  wire logic  [3:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             straps_valid,
	output logic             mii_isolate,
	output logic       [4:0] mgmt_addr,
	output logic             an_enable,
	output logic             speed_100,
	output logic             full_duplex,
	output logic       [3:0] adv_abilities
);
	typedef struct packed {
		rsl_pkg::rsl_state_e state;
		logic [4:0]          addr;
		logic                isolate;
		logic                neg_en;
		logic                spd;
		logic                dpx;
		logic [3:0]          adv;
		logic [7:0]          raw;
		logic [15:0]         rdata;
		logic [7:0]          pout;
		logic [7:0]          poe;
	} rsl_latch_s;

	rsl_latch_s st_ff;
	rsl_latch_s nxt_st;
	logic [7:0] pin_sync;
	logic       dec_spd;
	logic       dec_dpx;
	logic [3:0] dec_adv;

	////////////////////////////////////////////////////////////////////////
	// pins synchronised
	rsl_sync #(
		.W (rsl_pkg::STRAP_W)
	) u_sync (
		.mclk (mclk),
		.d    (strap_pin_in),
		.q    (pin_sync)
	);

	rsl_mode_dec u_dec (
		.abil_high   (pin_sync[rsl_pkg::PIN_ABIL_HIGH]),
		.abil_low    (pin_sync[rsl_pkg::PIN_ABIL_LOW]),
		.speed_100   (dec_spd),
		.full_duplex (dec_dpx),
		.adv         (dec_adv)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.rdata = '0;
		case (st_ff.state)
			rsl_pkg::RSL_ST_CAPTURE: begin
				nxt_st.raw   = pin_sync;
				nxt_st.addr  = pin_sync[rsl_pkg::PIN_ADDR_LO +: rsl_pkg::ADDR_W];
				nxt_st.isolate = (pin_sync[rsl_pkg::PIN_ADDR_LO +: rsl_pkg::ADDR_W]
					== rsl_pkg::ISOLATE_ADDR);
				nxt_st.neg_en = pin_sync[rsl_pkg::PIN_NEG_EN];
				nxt_st.spd    = dec_spd;
				nxt_st.dpx    = dec_dpx;
				nxt_st.adv    = dec_adv;
				nxt_st.state  = rsl_pkg::RSL_ST_RUN;
			end
			rsl_pkg::RSL_ST_RUN: begin
				nxt_st.pout = {indicator_func_out, mii_func_out};
				// Isolated MII keeps its outputs off
				nxt_st.poe  = {3'h7, {5{~st_ff.isolate}}};
				if (reg_wr) begin
					case (reg_addr)
						rsl_pkg::OFS_CTRL: begin
							nxt_st.addr = reg_wdata[rsl_pkg::ADDR_W-1:0];
						end
						rsl_pkg::OFS_BASIC: begin
							nxt_st.neg_en = reg_wdata[rsl_pkg::BAS_NEG_BIT];
							nxt_st.spd    = reg_wdata[rsl_pkg::BAS_SPD_BIT];
							nxt_st.dpx    = reg_wdata[rsl_pkg::BAS_DPX_BIT];
						end
						rsl_pkg::OFS_ADV: begin
							nxt_st.adv = reg_wdata[rsl_pkg::ADV_W-1:0];
						end
						default: begin
							nxt_st.state = st_ff.state;
						end
					endcase
				end
			end
			default: begin
				nxt_st.state = rsl_pkg::RSL_ST_CAPTURE;
			end
		endcase
		if (reg_rd) begin
			case (reg_addr)
				rsl_pkg::OFS_CTRL: begin
					nxt_st.rdata[rsl_pkg::ADDR_W-1:0]     = st_ff.addr;
					nxt_st.rdata[rsl_pkg::CTRL_ISO_BIT]   = st_ff.isolate;
				end
				rsl_pkg::OFS_BASIC: begin
					nxt_st.rdata[rsl_pkg::BAS_NEG_BIT] = st_ff.neg_en;
					nxt_st.rdata[rsl_pkg::BAS_SPD_BIT] = st_ff.spd;
					nxt_st.rdata[rsl_pkg::BAS_DPX_BIT] = st_ff.dpx;
				end
				rsl_pkg::OFS_ADV: begin
					nxt_st.rdata[rsl_pkg::ADV_W-1:0] = st_ff.adv;
				end
				rsl_pkg::OFS_STRAP: begin
					nxt_st.rdata[rsl_pkg::STRAP_W-1:0] = st_ff.raw;
					nxt_st.rdata[rsl_pkg::STR_VAL_BIT]  = (st_ff.state == rsl_pkg::RSL_ST_RUN);
				end
				default: begin
					nxt_st.rdata = '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff.state   <= rsl_pkg::RSL_ST_CAPTURE;
			st_ff.addr    <= rsl_pkg::ADDR_DEFAULT;
			st_ff.isolate <= 1'b0;
			st_ff.neg_en  <= rsl_pkg::NEG_DEFAULT[2];
			st_ff.spd     <= rsl_pkg::NEG_DEFAULT[1];
			st_ff.dpx     <= rsl_pkg::NEG_DEFAULT[0];
			st_ff.adv     <= rsl_pkg::ADV_ALL;
			st_ff.raw     <= {rsl_pkg::NEG_DEFAULT, rsl_pkg::ADDR_DEFAULT};
			st_ff.rdata   <= '0;
			st_ff.pout    <= '0;
			st_ff.poe     <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign strap_pin_out = st_ff.pout;
	assign strap_pin_oe  = st_ff.poe;
	assign reg_rdata     = st_ff.rdata;
	assign straps_valid  = (st_ff.state == rsl_pkg::RSL_ST_RUN);
	assign mii_isolate   = st_ff.isolate;
	assign mgmt_addr     = st_ff.addr;
	assign an_enable     = st_ff.neg_en;
	assign speed_100     = st_ff.spd;
	assign full_duplex   = st_ff.dpx;
	assign adv_abilities = st_ff.adv;
endmodule

// file: test/rsl_strap_model.sv
`timescale 1ns/1ns
module rsl_strap_model (
	input  wire logic [7:0] drv,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] fit_en,
	input  wire logic [7:0] fit_val,
	output logic      [7:0] pad
);
	// Weak pulls: bit 0 up, 4..1 down, 7..5 up
	localparam logic [7:0] PULL = 8'he1;
	assign pad = (oe & drv) | (~oe & fit_en & fit_val) | (~oe & ~fit_en & PULL);
endmodule

// file: test/rsl_strap_latch_asserts.sv
`timescale 1ns/1ns
module rsl_strap_latch_asserts (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic [7:0] strap_pin_in,
	input wire logic [7:0] strap_pin_out,
	input wire logic [7:0] strap_pin_oe,
	input wire logic [4:0] mii_func_out,
	input wire logic [2:0] indicator_func_out,
	input wire logic       reg_wr,
	input wire logic       straps_valid,
	input wire logic       mii_isolate,
	input wire logic [4:0] mgmt_addr,
	input wire logic       an_enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_oe_capture: assert property ($rose(straps_valid) |-> strap_pin_oe == 8'h00)
		else $error("drivers on in capture cycle");
	a_addr_cap: assert property ($rose(straps_valid) |-> mgmt_addr == $past(strap_pin_in[4:0], 2)
		&& an_enable == $past(strap_pin_in[7], 2)) else $error("straps not captured");
	a_iso_strap: assert property ($rose(straps_valid) |-> mii_isolate == (mgmt_addr == 5'h00))
		else $error("isolate does not follow address");
	a_iso_hold: assert property (straps_valid && $past(straps_valid) |-> $stable(mii_isolate))
		else $error("isolate changed");
	a_valid_stays: assert property (straps_valid |=> straps_valid)
		else $error("valid dropped");
	a_oe_func: assert property (straps_valid && $past(straps_valid)
		|-> strap_pin_oe == {3'h7, {5{!mii_isolate}}}) else $error("bad enables");
	a_out_func: assert property (straps_valid && $past(straps_valid)
		|-> strap_pin_out == $past({indicator_func_out, mii_func_out})) else $error("bad drive");
	a_cfg_hold: assert property (straps_valid && !reg_wr
		|=> $stable(mgmt_addr) && $stable(an_enable)) else $error("config moved");
endmodule
bind rsl_strap_latch rsl_strap_latch_asserts chk_u (.mclk(mclk), .rst_b(rst_b),
	.strap_pin_in(strap_pin_in), .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe),
	.mii_func_out(mii_func_out), .indicator_func_out(indicator_func_out), .reg_wr(reg_wr),
	.straps_valid(straps_valid), .mii_isolate(mii_isolate), .mgmt_addr(mgmt_addr),
	.an_enable(an_enable));

// file: test/reset_strap_latch_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module reset_strap_latch_bench;
	logic        mclk = 0;
	logic        rst_b = 0;
	logic  [7:0] pad, p_out, p_oe, p, fit_en = 0, fit_val = 0, func = 0;
	logic  [3:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic        reg_wr = 0, reg_rd = 0, vld, iso, an, spd, dpx;
	logic  [4:0] addr;
	logic  [3:0] adv, ea;
	int          n_errors = 0, checks_done = 0;
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) func <= func + 8'h01;
	rsl_strap_model pm_u (.drv(p_out), .oe(p_oe), .fit_en(fit_en), .fit_val(fit_val), .pad(pad));
	rsl_strap_latch dut_u (.mclk(mclk), .rst_b(rst_b), .strap_pin_in(pad), .strap_pin_out(p_out),
		.strap_pin_oe(p_oe), .mii_func_out(func[4:0]), .indicator_func_out(func[7:5]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .straps_valid(vld), .mii_isolate(iso), .mgmt_addr(addr),
		.an_enable(an), .speed_100(spd), .full_duplex(dpx), .adv_abilities(adv));
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		logic [15:0] d;
		// Last pass leaves every pad on its internal pull
		for (int i = 0; i <= 8; i++) begin
			p  = (i == 8) ? 8'he1 : {i[2:0], 5'(i * 9)};
			ea = p[6] ? (p[5] ? 4'hf : 4'h5) : (p[5] ? 4'hc : 4'h3);
			@(posedge mclk);
			fit_en  <= (i == 8) ? 8'h00 : 8'hff;
			fit_val <= {i[2:0], 5'(i * 9)};
			rst_b   <= 1'b0;
			repeat (249) @(posedge mclk);
			#1;
			`CHK({vld, p_oe, p_out}, 17'h00000)
			`CHK({an, spd, dpx, adv}, {rsl_pkg::NEG_DEFAULT, rsl_pkg::ADV_ALL})
			`CHK(addr, rsl_pkg::ADDR_DEFAULT)
			@(posedge mclk);
			rst_b     <= 1'b1;
			// Write in the capture cycle must be refused
			reg_wr    <= 1'b1;
			reg_addr  <= rsl_pkg::OFS_BASIC;
			reg_wdata <= {13'h0000, ~p[5], ~p[6], ~p[7]};
			@(posedge mclk);
			reg_wr <= 1'b0;
			repeat (2) @(posedge mclk);
			#1;
			`CHK({an, spd, dpx, addr}, p[7:0])
			`CHK(iso, p[4:0] == 5'h00)
			`CHK(p_oe, {3'h7, {5{p[4:0] != 5'h00}}})
			`CHK({vld, adv}, {1'b1, ea})
			`CHK(p_out, func - 8'h01)
			// Pads flip once drivers own them; raw straps must not
			@(posedge mclk) fit_val <= ~fit_val;
			rd(rsl_pkg::OFS_STRAP, d);
			`CHK(d, {7'h00, 1'b1, p})
			rd(rsl_pkg::OFS_BASIC, d);
			`CHK(d, {13'h0000, p[5], p[6], p[7]})
			rd(rsl_pkg::OFS_ADV, d);
			`CHK(d, {12'h000, ea})
			wr(rsl_pkg::OFS_CTRL, 16'h0000);
			rd(rsl_pkg::OFS_CTRL, d);
			`CHK(d, {10'h000, p[4:0] == 5'h00, 5'h00})
			// Non-zero address and an unmapped write leave isolate alone
			wr(rsl_pkg::OFS_CTRL, 16'h0015);
			wr(4'hf, 16'hffff);
			rd(rsl_pkg::OFS_CTRL, d);
			`CHK(d, {10'h000, p[4:0] == 5'h00, 5'h15})
			rd(4'hf, d);
			`CHK(d, 16'h0000)
			wr(rsl_pkg::OFS_BASIC, 16'h0005);
			wr(rsl_pkg::OFS_ADV, 16'h0009);
			#1;
			`CHK({an, spd, dpx, adv}, 7'h59)
			rd(rsl_pkg::OFS_BASIC, d);
			`CHK(d, 16'h0005)
		end
		results();
	end
	initial begin
		#40000;
		n_errors++;
		results();
	end
endmodule
